// ==== verilog/ufc_core.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ufc_map.svh"
module ufc_core #(
	parameter int DEPTH     = `UFC_EP0_DEPTH,
	parameter int FNW       = 11,
	parameter int SUSP_CYC  = `UFC_SUSP_CYC,
	parameter int FRAME_CYC = `UFC_FRAME_CYC
) (
	input  wire logic            clk,
	input  wire logic            sys_rst,
	input  wire logic [7:0]      avs_address,
	input  wire logic            avs_read,
	input  wire logic            avs_write,
	input  wire logic [31:0]     avs_writedata,
	input  wire logic [3:0]      avs_byteenable,
	output logic [31:0]          avs_readdata,
	output logic                 avs_waitrequest,
	input  wire logic            dpPin,
	input  wire logic            dmPin,
	input  wire logic            sofRx,
	input  wire logic            rxByte,
	input  wire logic [7:0]      rxData,
	input  wire logic            rxPktOk,
	input  wire logic            rxPktBad,
	input  wire logic            rxSetup,
	input  wire logic            statusStart,
	output logic                 txAvail,
	output logic [7:0]           txData,
	output logic                 txEnd,
	input  wire logic            txByte,
	input  wire logic            txAck,
	input  wire logic            txNak,
	input  wire logic [FNW-1:0]  fnEvt,
	output logic [5:0]           irqReq
);
	localparam int IW = $clog2(DEPTH);
	localparam int PW = IW + 1;

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	typedef struct packed {
		logic                       ack;
		logic [31:0]                rdData;
		logic [5:0]                 irqPend;
		logic [5:0]                 irqEn;
		logic [FNW-1:0]             fnIe;
		logic [FNW-1:0]             fnIs;
		logic                       outRdy;
		logic                       inRdy;
		logic                       setup;
		logic                       dataEnd;
		logic                       setupEnd;
		logic                       cont;
		logic                       dEndIe;
		logic                       artEn;
		logic [7:0]                 max_packet_size;
		logic [PW-1:0]              inWr;
		logic [PW-1:0]              inRd;
		logic [PW-1:0]              inPkt;
		logic [PW-1:0]              outWr;
		logic [PW-1:0]              outRd;
		logic [PW-1:0]              outPkt;
		ufc_pkg::ufc_byte_t         txData;
		ufc_pkg::ufc_byte_t [DEPTH-1:0] inMem;
		ufc_pkg::ufc_byte_t [DEPTH-1:0] outMem;
	} ufc_core_t;

	localparam ufc_core_t RST_VAL = '{max_packet_size: `UFC_MAX_PACKET_SIZE_RST, default: '0};

	ufc_core_t      s;
	ufc_core_t      n;
	ufc_core_t      keep;
	logic           req;
	logic           wrHit;
	logic           rdHit;
	logic [31:0]    cur;
	logic [15:0]    m;
	logic [15:0]    wv;
	logic [15:0]    wc;
	logic [PW-1:0]  wp;
	logic [PW-1:0]  rp;
	logic [PW-1:0]  len;
	logic           ep0Evt;

	ufc_evt_if ev ();

	//------------------------------------------------------------
	// Line monitor
	//------------------------------------------------------------
	ufc_bus_mon #(
		.SE0_CYC   (`UFC_SE0_CYC),
		.SUSP_CYC  (SUSP_CYC),
		.FRAME_CYC (FRAME_CYC)
	) u_mon (
		.clk     (clk),
		.sys_rst (sys_rst),
		.dpPin   (dpPin),
		.dmPin   (dmPin),
		.ev      (ev.mon)
	);

	assign ev.sofRx = sofRx;
	assign ev.artEn = s.artEn;

	//------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------
	// Lane mask of an 8 or 16 bit access
	function automatic logic [15:0] laneMask(input logic [3:0] be);
		laneMask = {{8{be[1]}}, {8{be[0]}}};
	endfunction

	// Buffer index from a pointer
	function automatic logic [IW-1:0] idx(input logic [PW-1:0] p);
		idx = p[IW-1:0];
	endfunction

	//------------------------------------------------------------
	// Register readback
	//------------------------------------------------------------
	always_comb
	begin
		cur = '0;
		if (avs_address == `UFC_A_IRQ)
			cur = {18'h0, s.irqEn, 2'h0, s.irqPend};
		else if (avs_address == `UFC_A_FNIE)
			cur = 32'(s.fnIe);
		else if (avs_address == `UFC_A_FNIS)
			cur = 32'(s.fnIs);
		else if (avs_address == `UFC_A_CSR)
			cur = {23'h0, s.dEndIe, s.cont, 2'h0, s.setupEnd,
				s.dataEnd, s.setup, s.inRdy, s.outRdy};
		else if (avs_address == `UFC_A_ISO)
			cur = {29'h0, s.artEn, 2'h0};
		else if (avs_address == `UFC_A_MAX_PACKET_SIZE)
			cur = {24'h0, s.max_packet_size};
		else if (avs_address == `UFC_A_OUTD)
			cur = {16'h0, s.outMem[idx(s.outRd + 1'b1)],
				s.outMem[idx(s.outRd)]};
		else
			cur = '0;
	end

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb
	begin
		n = s;
		keep = s;
		ep0Evt = 1'b0;
		req = avs_read | avs_write;
		wrHit = avs_write & s.ack;
		rdHit = avs_read & s.ack;
		m = laneMask(avs_byteenable);
		wv = (cur[15:0] & ~m) | (avs_writedata[15:0] & m);
		wc = avs_writedata[15:0] & m;
		wp = s.inWr;
		rp = s.outRd;
		len = s.outWr - s.outPkt;

		// Bus handshake: one wait cycle, data latched meanwhile
		n.ack = req & ~s.ack;
		if (avs_read & ~s.ack)
			n.rdData = cur;

		// Register writes, clears before hardware sets
		if (wrHit)
		begin
			if (avs_address == `UFC_A_IRQ)
			begin
				n.irqEn = wv[13:8];
				n.irqPend = s.irqPend & ~wc[5:0];
			end
			else if (avs_address == `UFC_A_FNIE)
				n.fnIe = wv[FNW-1:0];
			else if (avs_address == `UFC_A_FNIS)
				n.fnIs = s.fnIs & ~wc[FNW-1:0];
			else if (avs_address == `UFC_A_CSR)
			begin
				n.dataEnd = wv[`UFC_CSR_DEND];
				n.cont = wv[`UFC_CSR_CONT];
				n.dEndIe = wv[`UFC_CSR_DENDIE];
				n.setup = s.setup & ~wc[`UFC_CSR_SETUP];
				n.setupEnd = s.setupEnd & ~wc[`UFC_CSR_SEND];
				// Data-end clear as a maskable event
				if (s.dataEnd && !wv[`UFC_CSR_DEND] && s.dEndIe)
					ep0Evt = 1'b1;
				// IN hand-over, also a zero-length packet
				if (wc[`UFC_CSR_SETIN])
				begin
					n.inRdy = 1'b1;
					n.inRd = '0;
					n.inPkt = '0;
				end
				// OUT buffer handed back by software
				if (wc[`UFC_CSR_OUTCLR])
				begin
					n.outRdy = 1'b0;
					n.outWr = '0;
					n.outRd = '0;
					n.outPkt = '0;
				end
			end
			else if (avs_address == `UFC_A_ISO)
				n.artEn = wv[`UFC_ISO_ART];
			else if (avs_address == `UFC_A_MAX_PACKET_SIZE)
				n.max_packet_size = wv[7:0];
			else if (avs_address == `UFC_A_IND)
			begin
				// Load IN buffer, one or two bytes
				for (int i = 0; i < 2; i++)
				begin
					if (avs_byteenable[i] && wp < PW'(DEPTH))
					begin
						n.inMem[idx(wp)] = avs_writedata[8*i +: 8];
						wp = wp + 1'b1;
					end
				end
				n.inWr = wp;
			end
		end

		// OUT buffer read advances the pointer on acceptance
		if (rdHit && avs_address == `UFC_A_OUTD)
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (avs_byteenable[i] && rp != s.outWr)
					rp = rp + 1'b1;
			end
			n.outRd = rp;
		end

		// IN side towards the host
		if (txByte && s.inRdy && s.inRd != s.inWr)
			n.inRd = s.inRd + 1'b1;
		if (txNak)
			n.inRd = s.inPkt;
		if (txAck && s.inRdy)
		begin
			if (s.cont && s.inRd != s.inWr)
				n.inPkt = s.inRd;
			else
			begin
				n.inRdy = 1'b0;
				n.inWr = '0;
				n.inRd = '0;
				n.inPkt = '0;
				ep0Evt = 1'b1;
			end
		end
		n.txData = n.inMem[idx(n.inRd)];

		// OUT side from the host
		if (rxByte && !s.outRdy && s.outWr < PW'(DEPTH))
		begin
			n.outMem[idx(s.outWr)] = rxData;
			n.outWr = s.outWr + 1'b1;
		end
		if (rxPktBad)
			n.outWr = s.outPkt;
		if (rxPktOk)
		begin
			n.outPkt = s.outWr;
			if (rxSetup)
			begin
				n.outRdy = 1'b1;
				n.setup = 1'b1;
				ep0Evt = 1'b1;
			end
			else if (!s.cont)
			begin
				n.outRdy = 1'b1;
				ep0Evt = 1'b1;
			end
			else if (s.outWr == PW'(DEPTH) || len < PW'(s.max_packet_size))
			begin
				n.outRdy = 1'b1;
				ep0Evt = 1'b1;
			end
		end

		// Status stage start
		if (statusStart)
		begin
			if (s.cont && s.outWr != '0 && !s.outRdy)
			begin
				n.outRdy = 1'b1;
				ep0Evt = 1'b1;
			end
			if (!s.dataEnd)
			begin
				n.setupEnd = 1'b1;
				ep0Evt = 1'b1;
			end
		end

		// Request flags, a set beats a same-cycle clear
		n.fnIs = n.fnIs | fnEvt;
		if (ep0Evt)
			n.irqPend[`UFC_IRQ_EP0] = 1'b1;
		if (|(n.fnIs & n.fnIe))
			n.irqPend[`UFC_IRQ_FN] = 1'b1;
		if (ev.resume)
			n.irqPend[`UFC_IRQ_RSM] = 1'b1;
		if (ev.suspend)
			n.irqPend[`UFC_IRQ_SUSP] = 1'b1;
		if (ev.sofTick)
			n.irqPend[`UFC_IRQ_SOF] = 1'b1;

		// Bus reset: defaults everywhere but the CPU side
		if (ev.busReset)
		begin
			keep = n;
			n = RST_VAL;
			n.ack = keep.ack;
			n.rdData = keep.rdData;
			n.irqEn = keep.irqEn;
			n.irqPend = keep.irqPend;
			n.irqPend[`UFC_IRQ_RST] = 1'b1;
		end
	end

	//------------------------------------------------------------
	// State register
	//------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			s <= RST_VAL;
		else
			s <= n;
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------
	// Bus answer
	assign avs_waitrequest = (avs_read | avs_write) & ~s.ack;
	assign avs_readdata = s.rdData;

	// Host-facing IN stream
	assign txAvail = s.inRdy;
	assign txData = s.txData;
	assign txEnd = (s.inRd == s.inWr) |
		(s.cont & ((s.inRd - s.inPkt) == PW'(s.max_packet_size)));

	// Gated requests to the CPU
	assign irqReq = s.irqPend & s.irqEn;
endmodule
`default_nettype wire

// ==== verilog/ufc_map.svh ====
// Function
// - Raise bus-reset request after SE0 on the lines for 2.5 us or more.
// - A bus reset returns every USB internal register to its default, except the interrupt enables and requests.
// - Raise suspend request after 3 ms of idle J state on the lines.
// - In suspend, any non-idle line state raises the resume request.
// - Raise a frame-start request for each received start-of-frame packet.
// - With artificial frame enabled, a frame timer stands in for lost SOFs.
// - Each of the six requests is gated by its own enable bit.
// - Control endpoint event on set received, set sent, or premature end.
// - Clearing data-end is a control endpoint event, maskable, masked at reset.
// - Function event on data endpoint events, flow errors, enables, lost final ACK.
// - Each function source has its own enable bit and status flag.
// - Control endpoint buffers: fixed 128 bytes IN and 128 bytes OUT at 3K.
// - Software may use 8-bit or 16-bit accesses to buffers and registers.
// - IN write pointer advances by two per word, by one per byte.
// - Plain mode: IN-ready set by software, cleared once the packet is sent.
// - Continuous mode: split the set into max-size packets, clear when done.
// - OUT read pointer advances two per word, one per byte, read while ready.
// - A setup packet sets OUT-ready and setup flags and an endpoint event.
// - Plain mode: OUT-ready set per packet, cleared by software write of 1.
// - Continuous mode: OUT-ready on full buffer, short packet or pending status.
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH
`define UFC_CLK_MHZ	250
`define UFC_SE0_NS	2500
`define UFC_SE0_CYC	((`UFC_SE0_NS * `UFC_CLK_MHZ + 999) / 1000)
`define UFC_SUSP_US	3000
`define UFC_SUSP_CYC	(`UFC_SUSP_US * `UFC_CLK_MHZ)
`define UFC_FRAME_US	1000
`define UFC_FRAME_CYC	(`UFC_FRAME_US * `UFC_CLK_MHZ)
`define UFC_EP0_BASE	16'h0C00
`define UFC_EP0_DEPTH	128
`define UFC_A_IRQ	8'h00
`define UFC_A_FNIE	8'h04
`define UFC_A_FNIS	8'h08
`define UFC_A_CSR	8'h0C
`define UFC_A_ISO	8'h10
`define UFC_A_MAX_PACKET_SIZE	8'h14
`define UFC_A_IND	8'h18
`define UFC_A_OUTD	8'h1C
`define UFC_IRQ_EP0	0
`define UFC_IRQ_FN	1
`define UFC_IRQ_RST	2
`define UFC_IRQ_RSM	3
`define UFC_IRQ_SUSP	4
`define UFC_IRQ_SOF	5
`define UFC_CSR_OUTRDY	0
`define UFC_CSR_INRDY	1
`define UFC_CSR_SETUP	2
`define UFC_CSR_DEND	3
`define UFC_CSR_SEND	4
`define UFC_CSR_SETIN	5
`define UFC_CSR_OUTCLR	6
`define UFC_CSR_CONT	7
`define UFC_CSR_DENDIE	8
`define UFC_ISO_ART	2
`define UFC_MAX_PACKET_SIZE_RST	8'h08
`endif

// ==== verilog/ufc_pkg.sv ====
package ufc_pkg;
	// Line monitor state
	typedef enum logic [1:0] {UFC_LN_ACT = 2'h1, UFC_LN_SUSP = 2'h2} ufc_line_t;
	typedef logic [7:0] ufc_byte_t;
endpackage

// ==== verilog/ufc_evt_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// Bus events between line monitor and core
interface ufc_evt_if;
	logic busReset;
	logic suspend;
	logic resume;
	logic sofTick;
	logic sofRx;
	logic artEn;
	modport mon (input sofRx, artEn,
		output busReset, suspend, resume, sofTick);
	modport core (output sofRx, artEn,
		input busReset, suspend, resume, sofTick);
endinterface
`default_nettype wire

// ==== verilog/ufc_bus_mon.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ufc_map.svh"
module ufc_bus_mon #(
	parameter int SE0_CYC   = `UFC_SE0_CYC,
	parameter int SUSP_CYC  = `UFC_SUSP_CYC,
	parameter int FRAME_CYC = `UFC_FRAME_CYC
) (
	input  wire logic   clk,
	input  wire logic   sys_rst,
	input  wire logic   dpPin,
	input  wire logic   dmPin,
	ufc_evt_if.mon      ev
);
	// Wide enough for the longest of the three counts
	localparam int CW = $clog2(SUSP_CYC + FRAME_CYC + SE0_CYC + 1);
	typedef struct packed {
		logic [1:0]       dp;
		logic [1:0]       dm;
		ufc_pkg::ufc_line_t line;
		logic [CW-1:0]    se0Cnt;
		logic [CW-1:0]    idleCnt;
		logic [CW-1:0]    frmCnt;
		logic             busReset;
		logic             suspend;
		logic             resume;
		logic             sofTick;
	} ufc_mon_t;
	localparam ufc_mon_t RST_VAL = '{line: ufc_pkg::UFC_LN_ACT, default: '0};
	ufc_mon_t s;
	ufc_mon_t n;
	logic     se0;
	logic     jIdle;

	//------------------------------------------------------------
	// Line state and frame timer
	//------------------------------------------------------------
	always_comb
	begin
		n = s;
		n.dp = {s.dp[0], dpPin};
		n.dm = {s.dm[0], dmPin};
		se0 = ~s.dp[1] & ~s.dm[1];
		jIdle = s.dp[1] & ~s.dm[1];
		n.busReset = 1'b0;
		n.suspend = 1'b0;
		n.resume = 1'b0;
		n.sofTick = 1'b0;
		// Single-ended zero long enough is a bus reset
		if (se0)
		begin
			if (s.se0Cnt != CW'(SE0_CYC))
				n.se0Cnt = s.se0Cnt + 1'b1;
			if (s.se0Cnt == CW'(SE0_CYC - 1))
				n.busReset = 1'b1;
		end
		else
			n.se0Cnt = '0;
		// Idle J counts towards suspend, anything else wakes
		if (jIdle)
		begin
			if (s.idleCnt != CW'(SUSP_CYC))
				n.idleCnt = s.idleCnt + 1'b1;
			if (s.idleCnt == CW'(SUSP_CYC - 1) && s.line == ufc_pkg::UFC_LN_ACT)
			begin
				n.suspend = 1'b1;
				n.line = ufc_pkg::UFC_LN_SUSP;
			end
		end
		else
		begin
			n.idleCnt = '0;
			case (s.line)
				ufc_pkg::UFC_LN_SUSP:
				begin
					n.resume = 1'b1;
					n.line = ufc_pkg::UFC_LN_ACT;
				end
				default:
					n.line = ufc_pkg::UFC_LN_ACT;
			endcase
		end
		// Frame timer restarts on every SOF, stands in on a lost one
		if (ev.sofRx)
		begin
			n.frmCnt = '0;
			n.sofTick = 1'b1;
		end
		else if (s.frmCnt == CW'(FRAME_CYC - 1))
		begin
			n.frmCnt = '0;
			n.sofTick = ev.artEn;
		end
		else
			n.frmCnt = s.frmCnt + 1'b1;
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			s <= RST_VAL;
		else
			s <= n;
	end

	assign ev.busReset = s.busReset;
	assign ev.suspend = s.suspend;
	assign ev.resume = s.resume;
	assign ev.sofTick = s.sofTick;
endmodule
`default_nettype wire

// ==== tb/ufc_core_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ufc_map.svh"
module ufc_core_chk #(
	parameter int SUSP_CYC  = 200,
	parameter int FRAME_CYC = 300
) (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest,
	input wire logic        dpPin,
	input wire logic        dmPin,
	input wire logic        sofRx,
	input wire logic        txAvail,
	input wire logic        txEnd,
	input wire logic        txAck,
	input wire logic [5:0]  irqReq
);
	int  jCnt;
	int  se0Cnt;
	int  sofAge;
	wire se0 = !dpPin && !dmPin;
	wire setIn = avs_write && !avs_waitrequest && avs_byteenable[0]
		&& avs_address == `UFC_A_CSR && avs_writedata[`UFC_CSR_SETIN];
	// Idle, SE0 and frame age counters
	always_ff @(posedge clk)
	begin
		jCnt   <= (sys_rst || !(dpPin && !dmPin)) ? 0 : jCnt + 1;
		se0Cnt <= (sys_rst || !se0) ? 0 : se0Cnt + 1;
		sofAge <= (sys_rst || sofRx) ? 0 : sofAge + 1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence sWait; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence sTake; (avs_read || avs_write) && !avs_waitrequest; endsequence
	AST_WAIT_ONE: assert property (sWait |=> !avs_waitrequest)
		else $error("bus request not answered in one cycle");
	AST_REARM: assert property (
		sTake ##1 (avs_read || avs_write) |-> avs_waitrequest)
		else $error("second request accepted without wait");
	AST_TX_SET: assert property (setIn |=> txAvail)
		else $error("IN ready not set by request bit");
	AST_TX_ROSE: assert property ($rose(txAvail) |-> $past(setIn))
		else $error("IN ready rose without request");
	AST_TX_FELL: assert property (
		$fell(txAvail) |-> $past(txAck) || $past(se0))
		else $error("IN ready fell without acknowledge");
	AST_SUSP: assert property ($rose(irqReq[4]) |-> jCnt >= SUSP_CYC)
		else $error("suspend raised before idle time");
	AST_BUS_RST: assert property ($rose(irqReq[2]) |-> se0Cnt >= `UFC_SE0_CYC)
		else $error("bus reset raised on short SE0");
	AST_BUS_CLR: assert property (
		$rose(irqReq[2]) |-> !txAvail && txEnd)
		else $error("bus reset left IN buffer armed");
	AST_SOF: assert property (
		$rose(irqReq[5]) && !$past(avs_write)
		|-> sofAge <= 3 || sofAge >= FRAME_CYC - 2)
		else $error("frame request at wrong time");
endmodule
bind ufc_core ufc_core_chk #(.SUSP_CYC(SUSP_CYC), .FRAME_CYC(FRAME_CYC))
	u_ufc_core_chk (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_waitrequest, .dpPin, .dmPin,
	.sofRx, .txAvail, .txEnd, .txAck, .irqReq);
`default_nettype wire

// ==== tb/ufc_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ufc_host_model (
	input  wire logic       clk,
	input  wire logic       txAvail,
	input  wire logic [7:0] txData,
	input  wire logic       txEnd,
	output logic            dpPin,
	output logic            dmPin,
	output logic            sofRx,
	output logic            rxByte,
	output logic [7:0]      rxData,
	output logic            rxPktOk,
	output logic            rxPktBad,
	output logic            rxSetup,
	output logic            statusStart,
	output logic            txByte,
	output logic            txAck,
	output logic            txNak
);
	logic [7:0] outQ[$];
	logic [7:0] inQ[$];
	// Idle J line, no traffic
	initial
	begin
		{sofRx, rxByte, rxData, rxPktOk, rxPktBad, rxSetup} = '0;
		{statusStart, txByte, txAck, txNak, dmPin} = '0;
		dpPin = 1'b1;
	end
	// Hold a line state, then back to idle J
	task automatic line(input logic dp, input logic dm, input int n);
		dpPin <= dp;
		dmPin <= dm;
		repeat (n) @(posedge clk);
		dpPin <= 1'b1;
		dmPin <= 1'b0;
	endtask
	task automatic sof();
		sofRx <= 1'b1;
		@(posedge clk);
		sofRx <= 1'b0;
		@(posedge clk);
	endtask
	// Status stage begins
	task automatic status();
		statusStart <= 1'b1;
		@(posedge clk);
		statusStart <= 1'b0;
	endtask
	// OUT or SETUP data packet, good bytes kept for the bench
	task automatic out_pkt(input int n, input logic stp,
		input logic bad = 1'b0);
		logic [7:0] b;
		for (int i = 0; i < n; i++)
		begin
			b = 8'($urandom);
			if (!bad)
				outQ.push_back(b);
			rxByte <= 1'b1;
			rxData <= b;
			@(posedge clk);
		end
		rxByte <= 1'b0;
		rxData <= ~rxData;
		rxPktOk <= !bad;
		rxPktBad <= bad;
		rxSetup <= stp;
		@(posedge clk);
		rxPktOk <= 1'b0;
		rxPktBad <= 1'b0;
		rxSetup <= 1'b0;
	endtask
	// IN packet: take bytes until the end mark, then acknowledge or refuse
	task automatic in_pkt(input logic nak, output int n);
		n = 0;
		@(posedge clk);
		while (!txEnd && n < 200)
		begin
			inQ.push_back(txData);
			n++;
			txByte <= 1'b1;
			@(posedge clk);
			txByte <= 1'b0;
			@(posedge clk);
		end
		txAck <= !nak;
		txNak <= nak;
		@(posedge clk);
		txAck <= 1'b0;
		txNak <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb/tb_usb_function_ep0_fifo_irq.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ufc_map.svh"
module tb_usb_function_ep0_fifo_irq;
	localparam int SUSP  = 200;
	localparam int FRAME = 300;
	logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest;
	logic [7:0]  avs_address, rxData, txData;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic        dpPin, dmPin, sofRx, rxByte, rxPktOk, rxPktBad, rxSetup;
	logic        statusStart, txAvail, txEnd, txByte, txAck, txNak;
	logic [10:0] fnEvt;
	logic [5:0]  irqReq;
	logic [31:0] expQ[$], mskQ[$];
	logic [7:0]  expIn[$];
	logic [15:0] w;
	int          bad_count, total_checks, n;
	ufc_core #(.SUSP_CYC(SUSP), .FRAME_CYC(FRAME)) u_ufc_core (.clk, .sys_rst,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .dpPin, .dmPin, .sofRx, .rxByte,
		.rxData, .rxPktOk, .rxPktBad, .rxSetup, .statusStart, .txAvail,
		.txData, .txEnd, .txByte, .txAck, .txNak, .fnEvt, .irqReq);
	ufc_host_model u_host (.clk, .txAvail, .txData, .txEnd, .dpPin, .dmPin,
		.sofRx, .rxByte, .rxData, .rxPktOk, .rxPktBad, .rxSetup, .statusStart,
		.txByte, .txAck, .txNak);
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(input string nm, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Avalon master: hold until waitrequest sampled low
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [15:0] d, input logic [1:0] be, input logic keep);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= {2'b00, be};
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		if (!keep)
		begin
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, a, d, 2'b11, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
		input logic keep);
		expQ.push_back(e);
		mskQ.push_back(m);
		bus(1'b0, a, 16'h0000, 2'b11, keep);
	endtask
	task automatic irq(input int k, input logic v);
		check("irqReq", 32'(irqReq[k]), 32'(v));
	endtask
	// Load IN bytes: words back to back, odd tail as a byte
	task automatic load(input int cnt);
		for (int i = 0; i < cnt; i += 2)
		begin
			w = 16'($urandom);
			expIn.push_back(w[7:0]);
			if (i + 1 < cnt) expIn.push_back(w[15:8]);
			bus(1'b1, `UFC_A_IND, w, (i + 1 < cnt) ? 2'b11 : 2'b01, i + 2 < cnt);
		end
	endtask
	// Refused packet keeps its bytes for the retry
	task automatic take(input int len, input logic nak = 1'b0);
		u_host.in_pkt(nak, n);
		check("packet length", n, len);
		for (int i = 0; i < len; i++)
			check("txData", u_host.inQ.pop_front(),
				nak ? expIn[i] : expIn.pop_front());
		@(posedge clk);
	endtask
	task automatic drain(input int words);
		for (int i = 0; i < words; i++)
		begin
			rd(`UFC_A_OUTD, {16'h0000, u_host.outQ[1], u_host.outQ[0]},
				32'h0000_FFFF, i + 1 < words);
			void'(u_host.outQ.pop_front());
			void'(u_host.outQ.pop_front());
		end
		u_host.outQ.delete();
	endtask
	// Read data scoreboard
	always @(posedge clk)
		if (avs_read && avs_waitrequest === 1'b0 && expQ.size() > 0)
			check("avs_readdata", avs_readdata & mskQ.pop_front(), expQ.pop_front());
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#100000;
		bad_count++;
		complete_run();
	end
	// ------
	// Tests
	// ------
	initial
	begin
		{avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
		{fnEvt, bad_count, total_checks} = '0;
		sys_rst = 1'b1;
		void'($urandom(32'h0000_9E9F));
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		wr(`UFC_A_IRQ, 16'h3F00);
		rd(`UFC_A_MAX_PACKET_SIZE, 32'h0000_0008, 32'h0000_00FF, 1'b0);
		rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
		rd(`UFC_A_CSR, 32'h0000_0000, 32'h0000_01FF, 1'b0);
		wr(`UFC_A_CSR, 16'h0108);
		wr(`UFC_A_CSR, 16'h0100);
		irq(0, 1'b1);
		wr(`UFC_A_CSR, 16'h0008);
		wr(`UFC_A_IRQ, 16'h3F01);
		wr(`UFC_A_CSR, 16'h0000);
		irq(0, 1'b0);
		w = 16'($urandom) & 16'h07FF;
		wr(`UFC_A_FNIE, w);
		rd(`UFC_A_FNIE, {16'h0000, w}, 32'h0000_07FF, 1'b0);
		$display("test registers done");
		for (int k = 0; k < 11; k++)
		begin
			wr(`UFC_A_FNIE, 16'h0001 << k);
			fnEvt <= 11'h001 << k;
			@(posedge clk);
			fnEvt <= '0;
			rd(`UFC_A_FNIS, 32'h0000_0001 << k, 32'h0000_07FF, 1'b0);
			wr(`UFC_A_FNIS, 16'h0001 << k);
		end
		irq(1, 1'b1);
		wr(`UFC_A_IRQ, 16'h3F02);
		irq(1, 1'b0);
		$display("test function sources done");
		load(3);
		wr(`UFC_A_CSR, 16'h0020);
		take(3);
		rd(`UFC_A_CSR, 32'h0000_0000, 32'h0000_0002, 1'b0);
		irq(0, 1'b1);
		wr(`UFC_A_IRQ, 16'h3F01);
		wr(`UFC_A_CSR, 16'h0020);
		check("zero length", 32'(txEnd & txAvail), 32'h0000_0001);
		take(0);
		load(2);
		wr(`UFC_A_CSR, 16'h0020);
		take(2, 1'b1);
		check("txAvail", 32'(txAvail), 32'h0000_0001);
		take(2);
		$display("test plain IN done");
		u_host.out_pkt(3, 1'b0, 1'b1);
		u_host.out_pkt(4, 1'b0);
		rd(`UFC_A_CSR, 32'h0000_0001, 32'h0000_0001, 1'b0);
		drain(2);
		wr(`UFC_A_CSR, 16'h0040);
		rd(`UFC_A_CSR, 32'h0000_0000, 32'h0000_0001, 1'b0);
		wr(`UFC_A_IRQ, 16'h3F01);
		u_host.out_pkt(8, 1'b1);
		rd(`UFC_A_CSR, 32'h0000_0005, 32'h0000_0005, 1'b0);
		irq(0, 1'b1);
		u_host.outQ.delete();
		wr(`UFC_A_CSR, 16'h0044);
		wr(`UFC_A_IRQ, 16'h3F01);
		$display("test plain OUT and setup done");
		wr(`UFC_A_MAX_PACKET_SIZE, 16'h0004);
		wr(`UFC_A_CSR, 16'h0080);
		load(10);
		wr(`UFC_A_CSR, 16'h00A0);
		take(4);
		check("txAvail", 32'(txAvail), 32'h0000_0001);
		take(4);
		take(2);
		rd(`UFC_A_CSR, 32'h0000_0000, 32'h0000_0002, 1'b0);
		u_host.out_pkt(4, 1'b0);
		rd(`UFC_A_CSR, 32'h0000_0000, 32'h0000_0001, 1'b0);
		u_host.out_pkt(2, 1'b0);
		rd(`UFC_A_CSR, 32'h0000_0001, 32'h0000_0001, 1'b0);
		drain(3);
		wr(`UFC_A_CSR, 16'h00C0);
		u_host.out_pkt(4, 1'b0);
		u_host.status();
		rd(`UFC_A_CSR, 32'h0000_0011, 32'h0000_0011, 1'b0);
		drain(2);
		wr(`UFC_A_CSR, 16'h0050);
		$display("test continuous done");
		wr(`UFC_A_IRQ, 16'h1F3F);
		u_host.sof();
		irq(5, 1'b0);
		wr(`UFC_A_IRQ, 16'h3F00);
		irq(5, 1'b1);
		wr(`UFC_A_IRQ, 16'h3F20);
		repeat (FRAME + 10) @(posedge clk);
		irq(5, 1'b0);
		wr(`UFC_A_ISO, 16'h0004);
		repeat (FRAME + 10) @(posedge clk);
		irq(5, 1'b1);
		$display("test frames done");
		wr(`UFC_A_IRQ, 16'h3F18);
		u_host.line(1'b0, 1'b1, 4);
		repeat (4) @(posedge clk);
		irq(3, 1'b1);
		repeat (SUSP / 2) @(posedge clk);
		irq(4, 1'b0);
		repeat (SUSP) @(posedge clk);
		irq(4, 1'b1);
		$display("test suspend and resume done");
		load(1);
		wr(`UFC_A_CSR, 16'h0020);
		u_host.line(1'b0, 1'b0, 600);
		repeat (4) @(posedge clk);
		irq(2, 1'b0);
		u_host.line(1'b0, 1'b0, 700);
		@(posedge clk);
		irq(2, 1'b1);
		check("txAvail", 32'(txAvail), 32'h0000_0000);
		rd(`UFC_A_MAX_PACKET_SIZE, 32'h0000_0008, 32'h0000_00FF, 1'b0);
		rd(`UFC_A_CSR, 32'h0000_0000, 32'h0000_00FF, 1'b0);
		wr(`UFC_A_IRQ, 16'h3F3F);
		irq(2, 1'b0);
		expIn.delete();
		$display("test bus reset done");
		check("reads left", expQ.size(), 32'h0000_0000);
		complete_run();
	end
endmodule
`default_nettype wire
